// ===== src/sfs_defs.vh
// Constants of the serial-flash status read block
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH
`define SFS_OP_READ_STATUS   8'h05
`define SFS_OP_WRITE_STAT1   8'h01
`define SFS_OP_WRITE_STAT2   8'h31
`define SFS_OP_WRITE_ENABLE  8'h06
`define SFS_OP_WRITE_DISABLE 8'h04
`define SFS_B1_LOCK_BIT      7
`define SFS_B1_ERR_BIT       5
`define SFS_B1_WPP_BIT       4
`define SFS_B1_SWP_HI        3
`define SFS_B1_SWP_LO        2
`define SFS_B1_WEL_BIT       1
`define SFS_BUSY_BIT         0
`define SFS_B2_SOFT_RESET_ENABLE_BIT      4
`define SFS_B2_SLE_BIT       3
`define SFS_B2_PS_BIT        2
`define SFS_B2_ES_BIT        1
`define SFS_SWP_ALL          2'h3
`define SFS_LOCK_RESET       1'b0
`define SFS_SOFT_RESET_ENABLE_RESET       1'b0
`define SFS_SLE_RESET        1'b0
`define SFS_WEL_RESET        1'b0
`define SFS_ERR_RESET        1'b0
`define SFS_BIT_LAST         3'h7
`endif

// ===== src/sfs_sync.v
// Two-stage synchroniser for a group of pin inputs
`default_nettype none
module sfs_sync #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] rst_val,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  // First stage is read only by the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      dout    <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
  // rst_val is unused in the reset branch by design: constants only
  wire unused_ok = &{1'b0, rst_val};
endmodule // sfs_sync
`default_nettype wire

// ===== src/sfs_status_read.v
// Serial flash status register bytes and their serial read/write commands
`default_nettype none
`include "sfs_defs.vh"
module sfs_status_read (
  input  wire       CORE_CLK,
  input  wire       RST_N,
  input  wire       CS_N,
  input  wire       SCK,
  input  wire       SI,
  input  wire       WP_N,
  input  wire       BUSY,
  input  wire       OP_DONE,
  input  wire       OP_FAIL,
  input  wire       PROG_SUSP,
  input  wire       ERASE_SUSP,
  input  wire [1:0] SWP_STATE,
  input  wire       SOFT_RESET,
  input  wire       WEL_CLEAR,
  output reg        SO,
  output reg        SO_OE,
  output reg        PROT_LOCK,
  output reg        RST_CMD_EN,
  output reg        LOCKDOWN_EN,
  output reg        WRITE_ENABLE_LATCH
);
  // Phases of a frame
  localparam PH_OPCODE = 2'd0;
  localparam PH_READ   = 2'd1;
  localparam PH_DATA   = 2'd2;
  localparam PH_IGNORE = 2'd3;

  // ----------------------------------------
  // Timing limits
  // ----------------------------------------
  // CS_N, SCK, SI and WP_N each pass two flops, so each serial edge is seen
  // three core clocks after it happens at the pin.
  // Each serial clock phase must last four core clocks or more;
  // a faster host loses bits without any warning.
  // The same lag delays the floating of the output after release,
  // which the host must allow for before it turns the bus round.

  wire [3:0] pins_sync;
  wire       sck_s;
  wire       si_s;
  wire       byte_end;
  wire       stat_write;
  reg        sck_d_ff;
  reg [1:0]  phase_ff;
  reg [1:0]  nxt_phase;
  reg [2:0]  bit_cnt_ff;
  reg [7:0]  shift_in_ff;
  reg [7:0]  cmd_ff;
  reg [7:0]  out_byte_ff;
  reg        byte_sel_ff;
  reg        err_ff;
  wire       cs_act;
  wire       sck_rise;
  wire       sck_fall;
  wire [7:0] rx_byte;
  wire       busy_s;
  wire       wp_n_s;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Serial clock is slow enough to be sampled by the core clock
  sfs_sync #(.WIDTH(4)) u_sync (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .rst_val (4'h1),
    .din     ({~CS_N, SCK, SI, WP_N}),
    .dout    (pins_sync)
  );

  assign cs_act     = pins_sync[3];
  assign sck_s      = pins_sync[2];
  assign si_s       = pins_sync[1];
  assign wp_n_s     = pins_sync[0];
  assign busy_s     = BUSY;
  assign sck_rise   = sck_s & ~sck_d_ff;
  assign sck_fall   = ~sck_s & sck_d_ff;
  assign rx_byte    = {shift_in_ff[6:0], si_s};
  // Last bit of a byte arrives on this rising edge
  assign byte_end   = cs_act & sck_rise & (bit_cnt_ff == `SFS_BIT_LAST);
  // Status write accepted only when enabled and idle
  assign stat_write = byte_end & (phase_ff == PH_DATA) & WRITE_ENABLE_LATCH & ~busy_s;

  // Assemble one live status byte
  function [7:0] status_byte;
    input       second;
    input       lock;
    input       err;
    input       wpn;
    input [1:0] software_protect_summary;
    input       write_enable_latch;
    input       busy;
    input       soft_reset_enable;
    input       sector_lockdown_enable;
    input       ps;
    input       es;
    begin
      status_byte = 8'h00;
      if (!second) begin
        status_byte[`SFS_B1_LOCK_BIT] = lock;
        status_byte[`SFS_B1_ERR_BIT] = err;
        status_byte[`SFS_B1_WPP_BIT] = wpn;
        status_byte[`SFS_B1_SWP_HI:`SFS_B1_SWP_LO] = software_protect_summary;
        status_byte[`SFS_B1_WEL_BIT] = write_enable_latch;
      end else begin
        status_byte[`SFS_B2_SOFT_RESET_ENABLE_BIT] = soft_reset_enable;
        status_byte[`SFS_B2_SLE_BIT] = sector_lockdown_enable;
        status_byte[`SFS_B2_PS_BIT] = ps;
        status_byte[`SFS_B2_ES_BIT] = es;
      end
      // reserved bits stay zero from the initial clear
      status_byte[`SFS_BUSY_BIT] = busy;
    end
  endfunction

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  // Decide the phase after a full opcode byte
  always @* begin
    nxt_phase = phase_ff;
    if (phase_ff == PH_OPCODE && byte_end) begin
      case (rx_byte)
        `SFS_OP_READ_STATUS: nxt_phase = PH_READ;
        `SFS_OP_WRITE_STAT1: nxt_phase = PH_DATA;
        `SFS_OP_WRITE_STAT2: nxt_phase = PH_DATA;
        default:             nxt_phase = PH_IGNORE;
      endcase
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  // Bit counter and phase restart with every frame; the opcode shifter is not cleared
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d_ff    <= 1'b0;
      phase_ff    <= PH_OPCODE;
      bit_cnt_ff  <= 3'h0;
      shift_in_ff <= 8'h00;
      cmd_ff      <= 8'h00;
    end else begin
      sck_d_ff <= sck_s;
      if (!cs_act) begin
        // release ends frame at any bit
        phase_ff   <= PH_OPCODE;
        bit_cnt_ff <= 3'h0;
      end else begin
        phase_ff <= nxt_phase;
        if (sck_rise) begin
          shift_in_ff <= rx_byte;
          bit_cnt_ff  <= bit_cnt_ff + 3'h1;
        end
        if (byte_end && phase_ff == PH_OPCODE) begin
          cmd_ff <= rx_byte;
        end
      end
    end
  end

  // ----------------------------------------
  // Status byte loader
  // ----------------------------------------
  // Built at the last rise of each byte, so values are at
  // most one byte time old when they leave the pin
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_byte_ff <= 8'h00;
      byte_sel_ff <= 1'b0;
    end else if (!cs_act) begin
      byte_sel_ff <= 1'b0;
    end else if (byte_end && phase_ff == PH_OPCODE) begin
      out_byte_ff <= status_byte(1'b0, PROT_LOCK, err_ff, wp_n_s, SWP_STATE, WRITE_ENABLE_LATCH,
                                 busy_s, RST_CMD_EN, LOCKDOWN_EN, PROG_SUSP, ERASE_SUSP);
      byte_sel_ff <= 1'b0;
    end else if (byte_end && phase_ff == PH_READ) begin
      out_byte_ff <= status_byte(~byte_sel_ff, PROT_LOCK, err_ff, wp_n_s, SWP_STATE, WRITE_ENABLE_LATCH,
                                 busy_s, RST_CMD_EN, LOCKDOWN_EN, PROG_SUSP, ERASE_SUSP);
      byte_sel_ff <= ~byte_sel_ff;
    end
  end

  // ----------------------------------------
  // Serial output driver
  // ----------------------------------------
  // Bits change on falling edges only; the host samples
  // on the rise, well after the bit has settled
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SO    <= 1'b0;
      SO_OE <= 1'b0;
    end else if (!cs_act) begin
      SO    <= 1'b0;
      SO_OE <= 1'b0;
    end else if (sck_fall && phase_ff == PH_READ) begin
      SO_OE <= 1'b1;
      SO    <= out_byte_ff[`SFS_BIT_LAST - bit_cnt_ff];
    end
  end

  // ----------------------------------------
  // Status storage
  // ----------------------------------------
  // Only an operation end touches it; aborted commands leave it
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_ff <= `SFS_ERR_RESET;
    end else if (OP_DONE) begin
      err_ff <= OP_FAIL;
    end
  end

  // ----------------------------------------
  // Write enable latch
  // ----------------------------------------
  // A clear beats a set in the same cycle: a reset operation
  // must never leave the device write enabled
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_ENABLE_LATCH <= `SFS_WEL_RESET;
    end else if (SOFT_RESET || WEL_CLEAR) begin
      WRITE_ENABLE_LATCH <= 1'b0;
    end else if (byte_end && phase_ff == PH_OPCODE) begin
      if (rx_byte == `SFS_OP_WRITE_ENABLE) begin
        WRITE_ENABLE_LATCH <= 1'b1;
      end else if (rx_byte == `SFS_OP_WRITE_DISABLE) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end
    end else if (stat_write) begin
      // Accepted status write consumes the latch
      WRITE_ENABLE_LATCH <= 1'b0;
    end
  end

  // ----------------------------------------
  // Writable status bits
  // ----------------------------------------
  // Written on the data byte's last rise, not at release, so a
  // frame cut after the data byte still takes effect
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PROT_LOCK   <= `SFS_LOCK_RESET;
      RST_CMD_EN  <= `SFS_SOFT_RESET_ENABLE_RESET;
      LOCKDOWN_EN <= `SFS_SLE_RESET;
    end else if (stat_write) begin
      if (cmd_ff == `SFS_OP_WRITE_STAT1) begin
        // only bit 7; asserted pin allows locking only
        if (wp_n_s || rx_byte[`SFS_B1_LOCK_BIT]) begin
          PROT_LOCK <= rx_byte[`SFS_B1_LOCK_BIT];
        end
      end else begin
        RST_CMD_EN  <= rx_byte[`SFS_B2_SOFT_RESET_ENABLE_BIT];
        LOCKDOWN_EN <= rx_byte[`SFS_B2_SLE_BIT];
      end
    end
  end
endmodule // sfs_status_read
`default_nettype wire

// ===== tb/sfs_chk.sv
// Port checker for the status read block
`default_nettype none
module sfs_chk (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic PROT_LOCK,
  input wire logic RST_CMD_EN,
  input wire logic LOCKDOWN_EN,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic SOFT_RESET,
  input wire logic WEL_CLEAR
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so one clock and one reset for all
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_oe_release: assert property ($rose(CS_N) |-> ##[1:5] !SO_OE) else $error("output not floated");
  a_oe_idle: assert property (CS_N [*5] |-> !SO_OE) else $error("output driven while idle");
  a_oe_start: assert property ($rose(SO_OE) |-> !CS_N && !$past(CS_N, 8)) else $error("early drive");
  // Output bits move only in the low phase of the serial clock
  a_so_fall: assert property ($changed(SO) && SO_OE && $past(SO_OE) |-> !$past(SCK, 2)) else $error("bad shift");
  a_lock_idle: assert property (CS_N [*8] |=> $stable(PROT_LOCK)) else $error("lock moved");
  a_ctl_idle: assert property (CS_N [*8] |=> $stable({RST_CMD_EN, LOCKDOWN_EN})) else $error("enables moved");
  a_wel_reset: assert property (SOFT_RESET |-> ##[1:3] !WRITE_ENABLE_LATCH) else $error("latch kept over reset");
  a_wel_clear: assert property (WEL_CLEAR |-> ##[1:3] !WRITE_ENABLE_LATCH) else $error("latch kept over clear");
endmodule // sfs_chk
bind sfs_status_read sfs_chk u_chk (.CORE_CLK, .RST_N, .CS_N, .SCK, .SO, .SO_OE, .PROT_LOCK, .RST_CMD_EN,
  .LOCKDOWN_EN, .WRITE_ENABLE_LATCH, .SOFT_RESET, .WEL_CLEAR);
`default_nettype wire

// ===== tb/sfs_host.sv
// Host serial controller model, one frame at a time
`default_nettype none
module sfs_host (
  input  wire logic CORE_CLK,
  output var  logic CS_N = 1'h1,
  output var  logic SCK = 1'h0,
  output var  logic SI = 1'h0,
  input  wire logic SO,
  input  wire logic SO_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  // Step n core clocks, landing just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  // Clock parked low outside frames; each phase lasts 4 core clocks
  task automatic frame(input logic [15:0] tx, input int nt, input int nr, output logic [31:0] rx);
    rx = 32'h0;
    CS_N = 1'h0;
    tick(4);
    // opcode MSB first, then as many reads as asked
    for (int i = 0; i < nt + nr; i++) begin
      SCK = 1'h0;
      SI = (i < nt) ? tx[15 - i] : ~SI;
      tick(4);
      SCK = 1'h1;
      tick(3);
      rx = {rx[30:0], SO_OE ? SO : ~rx[0]};
      tick(1);
    end
    SCK = 1'h0;
    tick(4);
    CS_N = 1'h1;
    tick(6);
  endtask
endmodule // sfs_host
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the status read block
`default_nettype none
`include "sfs_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CORE_CLK = 1'h0, RST_N = 1'h0, WP_N = 1'h1, BUSY = 1'h0, OP_DONE = 1'h0, OP_FAIL = 1'h0;
  logic        PROG_SUSP = 1'h0, ERASE_SUSP = 1'h0, SOFT_RESET = 1'h0, WEL_CLEAR = 1'h0;
  logic        CS_N, SCK, SI, SO, SO_OE, PROT_LOCK, RST_CMD_EN, LOCKDOWN_EN, WRITE_ENABLE_LATCH;
  logic [1:0]  SWP_STATE = 2'h3;
  logic [15:0] e0;
  logic [31:0] rx;
  int          miscompares = 0, samples_checked = 0;
  sfs_status_read DUT (.CORE_CLK, .RST_N, .CS_N, .SCK, .SI, .WP_N, .BUSY, .OP_DONE, .OP_FAIL, .PROG_SUSP,
    .ERASE_SUSP, .SWP_STATE, .SOFT_RESET, .WEL_CLEAR, .SO, .SO_OE, .PROT_LOCK, .RST_CMD_EN, .LOCKDOWN_EN, .WRITE_ENABLE_LATCH);
  sfs_host host (.CORE_CLK, .CS_N, .SCK, .SI, .SO, .SO_OE);
  // Core clock, 50 ns period
  initial forever #25 CORE_CLK = ~CORE_CLK;
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Both bytes from the live inputs plus the stored bits
  function automatic logic [15:0] want(input logic lk, er, we, rs, sl);
    return {lk, 1'h0, er, WP_N, SWP_STATE, we, BUSY, 3'h0, rs, sl, PROG_SUSP, ERASE_SUSP, BUSY};
  endfunction
  task automatic pulse(ref logic s);
    s = 1'h1;
    host.tick(1);
    s = 1'h0;
    host.tick(1);
  endtask
  // Four bytes read; the later pair is the one a fast host trusts
  task automatic read_chk(input logic lk, er, we, rs, sl);
    host.frame({`SFS_OP_READ_STATUS, 8'h00}, 8, 32, rx);
    check("first pair", rx[31:16], want(lk, er, we, rs, sl));
    check("later pair", rx[15:0], want(lk, er, we, rs, sl));
  endtask
  task automatic t_fields;
    check("flags", 16'({PROT_LOCK, RST_CMD_EN, LOCKDOWN_EN, WRITE_ENABLE_LATCH}), 16'h0);
    for (int i = 0; i < 4; i++) begin
      {PROG_SUSP, WP_N} = 2'(i);
      SWP_STATE = 2'(i);
      ERASE_SUSP = ~PROG_SUSP;
      read_chk(0, 0, 0, 0, 0);
    end
  endtask
  // Busy rises in mid byte one; only later bytes may show it
  task automatic t_live;
    e0 = want(0, 0, 0, 0, 0);
    fork
      host.frame({`SFS_OP_READ_STATUS, 8'h00}, 8, 32, rx);
      begin
        host.tick(100);
        {BUSY, ERASE_SUSP} = 2'h3;
      end
    join
    check("byte one", {rx[31:24], 8'h00}, {e0[15:8], 8'h00});
    check("byte two", {8'h00, rx[23:16]}, want(0, 0, 0, 0, 0) & 16'h00FF);
    check("refresh", rx[15:0], want(0, 0, 0, 0, 0));
    read_chk(0, 0, 0, 0, 0);
    BUSY = 1'h0;
  endtask
  // Writes of all ones may touch only the writable bits
  task automatic t_writes;
    host.frame({`SFS_OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
    read_chk(0, 0, 1, 0, 0);
    host.frame({`SFS_OP_WRITE_STAT1, 8'hFF}, 16, 0, rx);
    pulse(WEL_CLEAR);
    read_chk(1, 0, 0, 0, 0);
    host.frame({`SFS_OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
    host.frame({`SFS_OP_WRITE_STAT2, 8'hFF}, 16, 0, rx);
    pulse(WEL_CLEAR);
    read_chk(1, 0, 0, 1, 1);
    host.frame({`SFS_OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
    pulse(SOFT_RESET);
    check("flags", 16'({PROT_LOCK, RST_CMD_EN, LOCKDOWN_EN, WRITE_ENABLE_LATCH}), 16'h000E);
    // Asserted pin blocks unlocking; a write without the latch is refused
    WP_N = 1'h0;
    host.frame({`SFS_OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
    host.frame({`SFS_OP_WRITE_STAT1, 8'h00}, 16, 0, rx);
    host.frame({`SFS_OP_WRITE_STAT2, 8'h00}, 16, 0, rx);
    WP_N = 1'h1;
    check("refused", 16'({PROT_LOCK, RST_CMD_EN, LOCKDOWN_EN, WRITE_ENABLE_LATCH}), 16'h000E);
    host.frame({`SFS_OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
    check("latch set", 16'(WRITE_ENABLE_LATCH), 16'h1);
    host.frame({`SFS_OP_WRITE_DISABLE, 8'h00}, 8, 0, rx);
    check("latch off", 16'(WRITE_ENABLE_LATCH), 16'h0);
    host.frame({`SFS_OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
    pulse(WEL_CLEAR);
    check("latch clear", 16'(WRITE_ENABLE_LATCH), 16'h0);
  endtask
  task automatic t_err;
    for (int e = 1; e >= 0; e--) begin
      OP_FAIL = e[0];
      pulse(OP_DONE);
      read_chk(1, e[0], 0, 1, 1);
    end
  endtask
  task automatic t_abort;
    host.frame({`SFS_OP_READ_STATUS, 8'h00}, 8, 3, rx);
    check("float", 16'(SO_OE), 16'h0);
    read_chk(1, 0, 0, 1, 1);
  endtask
  // Reset for 5 clocks, then the scenarios in turn
  initial begin
    host.tick(5);
    RST_N = 1'h1;
    host.tick(3);
    t_fields();
    t_live();
    t_writes();
    t_err();
    t_abort();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
